// ===== inc/vss_regs.vh
`ifndef VSS_REGS_VH
`define VSS_REGS_VH
// Tick prescale: 1 ms tick at 125 MHz (1 ms / 8 ns)
`define VSS_CLK_NS 8
`define VSS_TICK_NS 1000000
`define VSS_TICK_DIV (`VSS_TICK_NS / `VSS_CLK_NS)
// Timer durations in seconds
`define VSS_LOCAL_RESTART_S 100
`define VSS_PEER_RESTART_S 120
`define VSS_STARTUP_PROT_S 60
// Ticks per second
`define VSS_TICKS_PER_S 1000
// Data link indices (sequential activation order)
`define VSS_DL_PROT0 0
`define VSS_DL_PROT1 1
`define VSS_DL_CTRL 2
`define VSS_DL_LINK 3
`define VSS_DL_BCC 4
`define VSS_DL_PSTN 5
`define VSS_NDL 6
// Link control FSM state codes
`define VSS_LC_FAIL 2'h0
`define VSS_LC_FAIL_BLK 2'h1
`define VSS_LC_OPER 2'h2
`define VSS_LC_OTHER 2'h3
// Initial FSM codes
`define VSS_FSM_OOS 2'h0
`define VSS_FSM_BLOCKED 2'h1
`define VSS_FSM_NULL 2'h2
`endif

// ===== hw/vss_timer.v
`default_nettype none
`include "vss_regs.vh"
module vss_timer (
  // Clock and control
  input wire clk,
  input wire rst,
  input wire ce,
  input wire tick,
  // Timer control
  input wire start,
  input wire stop,
  input wire [31:0] length,
  // Status
  output reg running_ff,
  output reg expire_ff
);
  reg [31:0] cnt_ff;
  always @(posedge clk) begin
    if (rst) begin
      running_ff <= 1'b0;
      expire_ff <= 1'b0;
      cnt_ff <= 32'h0;
    end else if (ce) begin
      expire_ff <= 1'b0;
      if (start) begin
        running_ff <= 1'b1;
        cnt_ff <= length;
      end else if (stop) begin
        running_ff <= 1'b0;
      end else if (running_ff && tick) begin
        if (cnt_ff <= 32'h1) begin
          running_ff <= 1'b0;
          expire_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 32'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/vss_sync.v
`default_nettype none
module vss_sync #(
  parameter W = 1
) (
  // Clock
  input wire clk,
  input wire ce,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q_ff
);
  reg [W-1:0] meta_ff;
  always @(posedge clk) begin
    if (ce) begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ===== hw/vss_startup.v
`default_nettype none
`include "vss_regs.vh"
module vss_startup (
  // Clock, reset, enable
  input wire CLK_SYS,
  input wire SRST,
  input wire CE,
  // Primary link pins
  input wire PRI_L1_OK,
  input wire PRI_FLAG_OK,
  // Start request and link block configuration
  input wire START_REQ,
  input wire [1:0] LINK_BLOCKED,
  input wire [1:0] LINK_STATE_IN,
  // Data link events, one bit per link
  input wire [5:0] DL_EST,
  input wire [5:0] DL_REL,
  input wire SWITCH_NEEDED,
  // Identity check
  input wire ID_DONE,
  input wire ID_MATCH,
  input wire LINK_ID_REJ,
  input wire LINK_ID_MISMATCH,
  // Restart events
  input wire PSTN_DL_FAIL,
  input wire CC_RESTART_REQ,
  input wire PEER_RESTART_DONE,
  input wire PSTN_ACK_ALL,
  // Data link requests
  output reg [5:0] DL_EST_REQ,
  output reg [5:0] SEQ_RESET,
  // Initial conditions
  output reg DEFAULT_PROFILE,
  output reg BEARER_DEALLOC,
  output reg [1:0] LINK_STATE_OUT,
  output reg [1:0] PROTO_FSM_INIT,
  output reg [1:0] PORT_FSM_INIT,
  // Traffic and procedures
  output reg CC_START_TRAFFIC,
  output reg PORT_LINK_START_TRAFFIC,
  output reg ID_CHECK_REQ,
  output reg LINK_BLOCK_IND,
  output reg PORT_UNBLOCK,
  output reg PSTN_UNBLOCK,
  output reg GROUP1_SWITCH_EN,
  output reg GROUP2_SWITCH_EN,
  output reg MGMT_NOTIFY,
  output reg NORMAL,
  output reg SUSPENDED,
  // Restart handshake
  output reg CC_RESTART_REQ_OUT,
  output reg PSTN_RESTART_REQ,
  output reg PSTN_RESTART_DONE,
  output reg CC_RESTART_DONE,
  output reg MAINT_ERROR
);
  ////////////////////////////////////////////////////////////////////////
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_INIT = 7'h02;
  localparam [6:0] S_ACT = 7'h04;
  localparam [6:0] S_IDCHK = 7'h08;
  localparam [6:0] S_BLOCK = 7'h10;
  localparam [6:0] S_NORMAL = 7'h20;
  localparam [6:0] S_SUSP = 7'h40;
  localparam [31:0] LOCAL_TICKS = `VSS_LOCAL_RESTART_S * `VSS_TICKS_PER_S;
  localparam [31:0] PEER_TICKS = `VSS_PEER_RESTART_S * `VSS_TICKS_PER_S;
  localparam [31:0] PROT_TICKS = `VSS_STARTUP_PROT_S * `VSS_TICKS_PER_S;
  localparam [31:0] TICK_LAST = `VSS_TICK_DIV - 1;

  wire [1:0] pri_s;
  wire l1_ok = pri_s[0] & pri_s[1];
  vss_sync #(.W(2)) u_sync (
    .clk(CLK_SYS),
    .ce(CE),
    .d({PRI_FLAG_OK, PRI_L1_OK}),
    .q_ff(pri_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Tick prescaler
  reg [31:0] pre_ff;
  reg tick_ff;
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      pre_ff <= 32'h0;
      tick_ff <= 1'b0;
    end else if (CE) begin
      tick_ff <= (pre_ff == TICK_LAST);
      pre_ff <= (pre_ff == TICK_LAST) ? 32'h0 : pre_ff + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers
  reg loc_start, loc_stop, peer_start, peer_stop, prot_start, prot_stop;
  wire loc_run, loc_exp, peer_run, peer_exp, prot_run, prot_exp;
  vss_timer u_loc (
    .clk(CLK_SYS), .rst(SRST), .ce(CE), .tick(tick_ff),
    .start(loc_start), .stop(loc_stop), .length(LOCAL_TICKS),
    .running_ff(loc_run), .expire_ff(loc_exp)
  );
  vss_timer u_peer (
    .clk(CLK_SYS), .rst(SRST), .ce(CE), .tick(tick_ff),
    .start(peer_start), .stop(peer_stop), .length(PEER_TICKS),
    .running_ff(peer_run), .expire_ff(peer_exp)
  );
  vss_timer u_prot (
    .clk(CLK_SYS), .rst(SRST), .ce(CE), .tick(tick_ff),
    .start(prot_start), .stop(prot_stop), .length(PROT_TICKS),
    .running_ff(prot_run), .expire_ff(prot_exp)
  );

  ////////////////////////////////////////////////////////////////////////
  // Startup sequencer
  reg [6:0] st_ff, nxt_st;
  reg [5:0] est_ff;
  reg [2:0] seq_ff;
  reg any_est_ff;
  reg [6:0] resume_ff;
  wire [5:0] est_now = est_ff | DL_EST;
  wire three_up = est_now[`VSS_DL_CTRL] & est_now[`VSS_DL_LINK] & est_now[`VSS_DL_BCC];
  wire prot_down = ~est_now[`VSS_DL_PROT0] & ~est_now[`VSS_DL_PROT1];

  function [1:0] lc_init;
    input [1:0] s;
    begin
      case (s)
        `VSS_LC_FAIL: lc_init = `VSS_LC_FAIL;
        `VSS_LC_FAIL_BLK: lc_init = `VSS_LC_FAIL;
        default: lc_init = `VSS_LC_OPER;
      endcase
    end
  endfunction

  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE: if (START_REQ) nxt_st = S_INIT;
      S_INIT: if (l1_ok) nxt_st = S_ACT;
      S_ACT: if (three_up) nxt_st = S_IDCHK;
      S_IDCHK: if (ID_DONE) nxt_st = ID_MATCH ? S_BLOCK : S_INIT;
      S_BLOCK: if (!LINK_ID_REJ) nxt_st = S_NORMAL;
      S_NORMAL: nxt_st = S_NORMAL;
      S_SUSP: if (l1_ok) nxt_st = resume_ff;
      default: nxt_st = S_IDLE;
    endcase
    if (st_ff != S_IDLE && st_ff != S_NORMAL && st_ff != S_SUSP && st_ff != S_INIT && !l1_ok)
      nxt_st = S_SUSP;
    if (st_ff != S_NORMAL && SWITCH_NEEDED && prot_down)
      nxt_st = S_INIT;
    if (st_ff != S_NORMAL && st_ff != S_IDLE && prot_exp)
      nxt_st = S_INIT;
  end

  always @* begin
    prot_start = (st_ff != S_IDLE) && !any_est_ff && (DL_EST != 6'h0);
    prot_stop = (st_ff == S_NORMAL) || (nxt_st == S_INIT);
  end

  integer i;
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      st_ff <= S_IDLE;
      est_ff <= 6'h0;
      seq_ff <= 3'h0;
      any_est_ff <= 1'b0;
      resume_ff <= S_ACT;
      DL_EST_REQ <= 6'h0;
      SEQ_RESET <= 6'h0;
      DEFAULT_PROFILE <= 1'b0;
      BEARER_DEALLOC <= 1'b0;
      LINK_STATE_OUT <= `VSS_LC_FAIL;
      PROTO_FSM_INIT <= `VSS_FSM_OOS;
      PORT_FSM_INIT <= `VSS_FSM_BLOCKED;
      CC_START_TRAFFIC <= 1'b0;
      PORT_LINK_START_TRAFFIC <= 1'b0;
      ID_CHECK_REQ <= 1'b0;
      LINK_BLOCK_IND <= 1'b0;
      PORT_UNBLOCK <= 1'b0;
      PSTN_UNBLOCK <= 1'b0;
      GROUP1_SWITCH_EN <= 1'b0;
      GROUP2_SWITCH_EN <= 1'b0;
      MGMT_NOTIFY <= 1'b0;
      NORMAL <= 1'b0;
      SUSPENDED <= 1'b0;
    end else if (CE) begin
      st_ff <= nxt_st;
      DL_EST_REQ <= 6'h0;
      SEQ_RESET <= DL_EST & ~est_ff;
      CC_START_TRAFFIC <= 1'b0;
      PORT_LINK_START_TRAFFIC <= 1'b0;
      ID_CHECK_REQ <= 1'b0;
      LINK_BLOCK_IND <= 1'b0;
      PORT_UNBLOCK <= 1'b0;
      PSTN_UNBLOCK <= 1'b0;
      MGMT_NOTIFY <= 1'b0;
      est_ff <= (est_ff | DL_EST) & ~(DL_REL & ~DL_EST);
      if (prot_start)
        any_est_ff <= 1'b1;
      if (DL_EST[`VSS_DL_CTRL] && !est_ff[`VSS_DL_CTRL] && st_ff != S_IDLE)
        CC_START_TRAFFIC <= 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
        if (DL_REL[i] && st_ff != S_IDLE)
          DL_EST_REQ[i] <= 1'b1;
      end
      SUSPENDED <= (nxt_st == S_SUSP);
      if (st_ff != S_SUSP && nxt_st == S_SUSP)
        resume_ff <= st_ff;
      NORMAL <= (nxt_st == S_NORMAL);
      GROUP1_SWITCH_EN <= (nxt_st != S_IDLE) && (nxt_st != S_NORMAL);
      GROUP2_SWITCH_EN <= (nxt_st == S_NORMAL);
      case (st_ff)
        S_INIT: begin
          DEFAULT_PROFILE <= 1'b1;
          BEARER_DEALLOC <= 1'b1;
          LINK_STATE_OUT <= lc_init(LINK_STATE_IN);
          PROTO_FSM_INIT <= `VSS_FSM_OOS;
          PORT_FSM_INIT <= `VSS_FSM_BLOCKED;
          est_ff <= 6'h0;
          any_est_ff <= 1'b0;
          seq_ff <= 3'h0;
        end
        S_ACT: begin
          if (seq_ff < 3'h5) begin
            if (seq_ff == 3'h0)
              DL_EST_REQ[1:0] <= ~est_now[1:0];
            else
              DL_EST_REQ[seq_ff + 3'h1] <= ~est_now[seq_ff + 3'h1];
            seq_ff <= seq_ff + 3'h1;
          end
          if (nxt_st == S_IDCHK) begin
            PORT_LINK_START_TRAFFIC <= 1'b1;
            ID_CHECK_REQ <= 1'b1;
          end
        end
        S_IDCHK: if (ID_DONE && !ID_MATCH) MGMT_NOTIFY <= 1'b1;
        S_BLOCK: begin
          LINK_BLOCK_IND <= |LINK_BLOCKED | LINK_ID_MISMATCH;
          if (nxt_st == S_NORMAL)
            PORT_UNBLOCK <= 1'b1;
        end
        S_NORMAL: PSTN_UNBLOCK <= est_now[`VSS_DL_PSTN];
        default: ;
      endcase
      if (nxt_st == S_INIT && st_ff != S_IDLE && st_ff != S_INIT)
        DEFAULT_PROFILE <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PSTN restart handshake
  reg loc_done_ff, peer_done_ff, active_ff;
  wire begin_rst = !active_ff && (PSTN_DL_FAIL || CC_RESTART_REQ);
  wire peer_ev = PEER_RESTART_DONE && peer_run;
  wire ack_ev = PSTN_ACK_ALL && loc_run;
  wire loc_fin = loc_done_ff || ack_ev || loc_exp;
  wire peer_fin = peer_done_ff || peer_ev;

  always @* begin
    loc_start = begin_rst;
    peer_start = begin_rst;
    loc_stop = ack_ev;
    peer_stop = peer_ev;
  end

  always @(posedge CLK_SYS) begin
    if (SRST) begin
      loc_done_ff <= 1'b0;
      peer_done_ff <= 1'b0;
      active_ff <= 1'b0;
      CC_RESTART_REQ_OUT <= 1'b0;
      PSTN_RESTART_REQ <= 1'b0;
      PSTN_RESTART_DONE <= 1'b0;
      CC_RESTART_DONE <= 1'b0;
      MAINT_ERROR <= 1'b0;
    end else if (CE) begin
      CC_RESTART_REQ_OUT <= begin_rst && PSTN_DL_FAIL;
      PSTN_RESTART_REQ <= begin_rst;
      PSTN_RESTART_DONE <= 1'b0;
      CC_RESTART_DONE <= 1'b0;
      MAINT_ERROR <= 1'b0;
      if (begin_rst) begin
        active_ff <= 1'b1;
        loc_done_ff <= 1'b0;
        peer_done_ff <= 1'b0;
      end else if (active_ff) begin
        if (ack_ev || loc_exp) begin
          loc_done_ff <= 1'b1;
          CC_RESTART_DONE <= 1'b1;
        end
        if (loc_exp)
          MAINT_ERROR <= 1'b1;
        if (peer_ev)
          peer_done_ff <= 1'b1;
        if (peer_exp) begin
          MAINT_ERROR <= 1'b1;
          PSTN_RESTART_DONE <= 1'b1;
          active_ff <= 1'b0;
        end else if (loc_fin && peer_fin && (peer_ev || ack_ev || loc_exp)) begin
          PSTN_RESTART_DONE <= 1'b1;
          active_ff <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/vss_startup_props.sv
`default_nettype none
module vss_startup_props (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // Causes
  input wire logic [5:0] DL_EST,
  input wire logic CC_RESTART_REQ,
  input wire logic PSTN_DL_FAIL,
  input wire logic PEER_RESTART_DONE,
  input wire logic PSTN_ACK_ALL,
  // Effects
  input wire logic [5:0] DL_EST_REQ,
  input wire logic [5:0] SEQ_RESET,
  input wire logic CC_START_TRAFFIC,
  input wire logic PORT_LINK_START_TRAFFIC,
  input wire logic ID_CHECK_REQ,
  input wire logic GROUP2_SWITCH_EN,
  input wire logic NORMAL,
  input wire logic [1:0] PORT_FSM_INIT,
  input wire logic CC_RESTART_REQ_OUT,
  input wire logic PSTN_RESTART_REQ,
  input wire logic CC_RESTART_DONE,
  input wire logic PSTN_RESTART_DONE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);
  ////////////////////////////////////////////////////////////
  // Shadow of the two restart timers
  logic loc_run_ff;
  logic peer_run_ff;
  always @(posedge CLK_SYS) begin
    if (SRST || CC_RESTART_DONE) loc_run_ff <= 1'b0;
    else if (PSTN_RESTART_REQ) loc_run_ff <= 1'b1;
    if (SRST || PEER_RESTART_DONE || PSTN_RESTART_DONE) peer_run_ff <= 1'b0;
    else if (PSTN_RESTART_REQ) peer_run_ff <= 1'b1;
  end
  ////////////////////////////////////////////////////////////
  a_seq_after_est: assert property (SEQ_RESET != 6'h00 |-> (SEQ_RESET & ~$past(DL_EST)) == 6'h00)
    else $error("sequence reset without establish");
  a_cc_traffic_cause: assert property (CC_START_TRAFFIC |-> $past(DL_EST[2]))
    else $error("common traffic start without control link");
  a_id_with_traffic: assert property (PORT_LINK_START_TRAFFIC |-> ID_CHECK_REQ)
    else $error("traffic start without identity check");
  a_prot_pair_first: assert property (DL_EST_REQ[2] && !NORMAL |-> $past(DL_EST_REQ[1:0]) == 2'h3)
    else $error("control requested before protection pair");
  a_act_order: assert property (DL_EST_REQ[3] && !NORMAL |-> $past(DL_EST_REQ[2]))
    else $error("link control requested out of order");
  a_restart_cause: assert property (PSTN_RESTART_REQ |-> $past(CC_RESTART_REQ || PSTN_DL_FAIL))
    else $error("restart request without cause");
  a_cc_req_out: assert property (CC_RESTART_REQ_OUT |-> PSTN_RESTART_REQ && $past(PSTN_DL_FAIL))
    else $error("common control request without link failure");
  a_ack_ignored: assert property (PSTN_ACK_ALL && !loc_run_ff |=> !CC_RESTART_DONE)
    else $error("acknowledge taken while local timer idle");
  a_peer_ignored: assert property (
    PEER_RESTART_DONE && !peer_run_ff && !PSTN_ACK_ALL |=> !PSTN_RESTART_DONE)
    else $error("peer complete taken while peer timer idle");
  a_group2_normal: assert property (GROUP2_SWITCH_EN |-> NORMAL)
    else $error("group 2 switch-over outside normal state");
  a_reset_init: assert property (disable iff (1'b0) SRST |=> PORT_FSM_INIT == 2'h1)
    else $error("port status not blocked after reset");
endmodule
bind vss_startup vss_startup_props u_props (.CLK_SYS(CLK_SYS), .SRST(SRST), .DL_EST(DL_EST),
  .CC_RESTART_REQ(CC_RESTART_REQ), .PSTN_DL_FAIL(PSTN_DL_FAIL),
  .PEER_RESTART_DONE(PEER_RESTART_DONE), .PSTN_ACK_ALL(PSTN_ACK_ALL),
  .DL_EST_REQ(DL_EST_REQ), .SEQ_RESET(SEQ_RESET), .CC_START_TRAFFIC(CC_START_TRAFFIC),
  .PORT_LINK_START_TRAFFIC(PORT_LINK_START_TRAFFIC), .ID_CHECK_REQ(ID_CHECK_REQ),
  .GROUP2_SWITCH_EN(GROUP2_SWITCH_EN), .NORMAL(NORMAL), .PORT_FSM_INIT(PORT_FSM_INIT),
  .CC_RESTART_REQ_OUT(CC_RESTART_REQ_OUT), .PSTN_RESTART_REQ(PSTN_RESTART_REQ),
  .CC_RESTART_DONE(CC_RESTART_DONE), .PSTN_RESTART_DONE(PSTN_RESTART_DONE));
`default_nettype wire

// ===== verification/vss_far_end.sv
`default_nettype none
module vss_far_end (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Answer delay and stray acknowledge command
  input wire logic [3:0] dly,
  input wire logic poke,
  // Requests from the block
  input wire logic [5:0] est_req,
  input wire logic pstn_req,
  // Answers
  output logic [5:0] est,
  output logic ack_all
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt [6];
  logic [4:0] acnt;
  // Each data link and the PSTN FSMs answer after dly cycles
  always @(posedge clk) begin
    est <= 6'h00;
    ack_all <= poke;
    if (acnt == 5'h01) ack_all <= 1'b1;
    acnt <= rst ? 5'h00 : pstn_req ? {1'b0, dly} : (acnt != 5'h00) ? acnt - 5'h01 : acnt;
    for (int i = 0; i < 6; i++) begin
      if (rst) cnt[i] <= 5'h00;
      else if (est_req[i]) cnt[i] <= {1'b0, dly};
      else if (cnt[i] != 5'h00) begin
        cnt[i] <= cnt[i] - 5'h01;
        if (cnt[i] == 5'h01) est[i] <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/vss_startup_tb.sv
`default_nettype none
`include "vss_regs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module vss_startup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = 0, SRST = 1, CE = 1, PRI_L1_OK = 1, PRI_FLAG_OK = 0, START_REQ = 0;
  logic [1:0] LINK_BLOCKED = 2'h1, LINK_STATE_IN = 2'h0, exp_ls;
  logic [5:0] DL_EST, DL_REL = 6'h00, DL_EST_REQ, SEQ_RESET;
  logic SWITCH_NEEDED = 0, ID_DONE = 0, ID_MATCH = 0, LINK_ID_REJ = 0, LINK_ID_MISMATCH = 0;
  logic PSTN_DL_FAIL = 0, CC_RESTART_REQ = 0, PEER_RESTART_DONE = 0, PSTN_ACK_ALL, poke = 0;
  logic DEFAULT_PROFILE, CC_START_TRAFFIC, PORT_LINK_START_TRAFFIC, ID_CHECK_REQ;
  logic GROUP2_SWITCH_EN, NORMAL, CC_RESTART_REQ_OUT, PSTN_RESTART_REQ;
  logic PSTN_RESTART_DONE, CC_RESTART_DONE;
  logic BEARER_DEALLOC, LINK_BLOCK_IND, PORT_UNBLOCK, PSTN_UNBLOCK, GROUP1_SWITCH_EN;
  logic MGMT_NOTIFY, SUSPENDED, MAINT_ERROR;
  logic [1:0] LINK_STATE_OUT, PROTO_FSM_INIT, PORT_FSM_INIT;
  logic [3:0] dly = 4'h6;
  logic [18:0] exp_q[$], exp_w;
  int error_cnt = 0, samples_checked = 0;
  wire [18:0] ev = {DL_EST_REQ, SEQ_RESET, CC_START_TRAFFIC, PORT_LINK_START_TRAFFIC,
    ID_CHECK_REQ, CC_RESTART_REQ_OUT, PSTN_RESTART_REQ, CC_RESTART_DONE, PSTN_RESTART_DONE};
  vss_startup DUT (.CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE), .PRI_L1_OK(PRI_L1_OK),
    .PRI_FLAG_OK(PRI_FLAG_OK), .START_REQ(START_REQ), .LINK_BLOCKED(LINK_BLOCKED),
    .LINK_STATE_IN(LINK_STATE_IN), .DL_EST(DL_EST), .DL_REL(DL_REL),
    .SWITCH_NEEDED(SWITCH_NEEDED), .ID_DONE(ID_DONE), .ID_MATCH(ID_MATCH),
    .LINK_ID_REJ(LINK_ID_REJ), .LINK_ID_MISMATCH(LINK_ID_MISMATCH),
    .PSTN_DL_FAIL(PSTN_DL_FAIL), .CC_RESTART_REQ(CC_RESTART_REQ),
    .PEER_RESTART_DONE(PEER_RESTART_DONE), .PSTN_ACK_ALL(PSTN_ACK_ALL),
    .DL_EST_REQ(DL_EST_REQ), .SEQ_RESET(SEQ_RESET), .DEFAULT_PROFILE(DEFAULT_PROFILE),
    .BEARER_DEALLOC(BEARER_DEALLOC), .LINK_STATE_OUT(LINK_STATE_OUT),
    .PROTO_FSM_INIT(PROTO_FSM_INIT),
    .PORT_FSM_INIT(PORT_FSM_INIT), .CC_START_TRAFFIC(CC_START_TRAFFIC),
    .PORT_LINK_START_TRAFFIC(PORT_LINK_START_TRAFFIC), .ID_CHECK_REQ(ID_CHECK_REQ),
    .LINK_BLOCK_IND(LINK_BLOCK_IND), .PORT_UNBLOCK(PORT_UNBLOCK),
    .PSTN_UNBLOCK(PSTN_UNBLOCK), .GROUP1_SWITCH_EN(GROUP1_SWITCH_EN),
    .GROUP2_SWITCH_EN(GROUP2_SWITCH_EN), .MGMT_NOTIFY(MGMT_NOTIFY), .NORMAL(NORMAL),
    .SUSPENDED(SUSPENDED),
    .CC_RESTART_REQ_OUT(CC_RESTART_REQ_OUT), .PSTN_RESTART_REQ(PSTN_RESTART_REQ),
    .PSTN_RESTART_DONE(PSTN_RESTART_DONE), .CC_RESTART_DONE(CC_RESTART_DONE),
    .MAINT_ERROR(MAINT_ERROR));
  vss_far_end u_far (.clk(CLK_SYS), .rst(SRST), .dly(dly), .poke(poke),
    .est_req(DL_EST_REQ), .pstn_req(PSTN_RESTART_REQ), .est(DL_EST), .ack_all(PSTN_ACK_ALL));
  ////////////////////////////////////////////////////////////
  initial forever #4 CLK_SYS = ~CLK_SYS;
  // Every event cycle must match the oldest expectation
  always @(negedge CLK_SYS) begin
    if (!SRST && ev !== 19'h0) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("[FAIL] %0t unexpected event %h", $time, ev);
      end else begin
        exp_w = exp_q.pop_front();
        `CHK(ev, exp_w)
      end
    end
  end
  task automatic note(input logic [5:0] r, input logic [5:0] s, input logic [6:0] f);
    exp_q.push_back({r, s, f});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic drain(input string name);
    for (int i = 0; i < 300 && exp_q.size() != 0; i++) cyc(1);
    cyc(4);
    `CHK(exp_q.size(), 0)
    $display("test %s done", name);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge CLK_SYS);
    error_cnt++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hdaf0864f));
    dly = 4'h6 + 4'($urandom % 6);
    LINK_STATE_IN = 2'($urandom);
    exp_ls = (LINK_STATE_IN < 2'h2) ? `VSS_LC_FAIL : `VSS_LC_OPER;
    repeat (20) @(posedge CLK_SYS);
    #1 SRST = 0;
    cyc(1);
    `CHK(PORT_FSM_INIT, `VSS_FSM_BLOCKED)
    `CHK(PROTO_FSM_INIT, `VSS_FSM_OOS)
    // Flags not yet up: any request here is unexpected
    START_REQ = 1;
    cyc(1);
    START_REQ = 0;
    cyc(12);
    note(6'h03, 6'h00, 7'h00);
    for (int k = 2; k < 6; k++) note(6'h01 << k, 6'h00, 7'h00);
    note(6'h00, 6'h03, 7'h00);
    note(6'h00, 6'h04, 7'h40);
    note(6'h00, 6'h08, 7'h00);
    note(6'h00, 6'h10, 7'h30);
    note(6'h00, 6'h20, 7'h00);
    PRI_FLAG_OK = 1;
    for (int i = 0; i < 300 && ID_CHECK_REQ !== 1'b1; i++) cyc(1);
    LINK_ID_REJ = 1;
    ID_DONE = 1;
    ID_MATCH = 1;
    cyc(1);
    ID_DONE = 0;
    cyc(20);
    `CHK(NORMAL, 1'b0)
    `CHK(LINK_BLOCK_IND, 1'b1)
    `CHK(GROUP1_SWITCH_EN, 1'b1)
    LINK_ID_REJ = 0;
    for (int i = 0; i < 300 && NORMAL !== 1'b1; i++) cyc(1);
    `CHK(PORT_UNBLOCK, 1'b1)
    `CHK(NORMAL, 1'b1)
    `CHK(GROUP1_SWITCH_EN, 1'b0)
    `CHK(BEARER_DEALLOC, 1'b1)
    `CHK(SUSPENDED, 1'b0)
    `CHK(MGMT_NOTIFY, 1'b0)
    `CHK(GROUP2_SWITCH_EN, 1'b1)
    `CHK(LINK_STATE_OUT, exp_ls)
    `CHK(DEFAULT_PROFILE, 1'b1)
    drain("startup");
    `CHK(PSTN_UNBLOCK, 1'b1)
    // Stray completion and acknowledge with no restart running
    PEER_RESTART_DONE = 1;
    poke = 1;
    cyc(1);
    PEER_RESTART_DONE = 0;
    poke = 0;
    cyc(6);
    note(6'h00, 6'h00, 7'h04);
    note(6'h00, 6'h00, 7'h02);
    note(6'h00, 6'h00, 7'h01);
    CC_RESTART_REQ = 1;
    cyc(1);
    CC_RESTART_REQ = 0;
    cyc(2);
    CC_RESTART_REQ = 1;
    cyc(1);
    CC_RESTART_REQ = 0;
    for (int i = 0; i < 300 && exp_q.size() > 1; i++) cyc(1);
    cyc(2);
    PEER_RESTART_DONE = 1;
    cyc(1);
    PEER_RESTART_DONE = 0;
    drain("peer restart");
    note(6'h00, 6'h00, 7'h0c);
    note(6'h00, 6'h00, 7'h03);
    PSTN_DL_FAIL = 1;
    cyc(1);
    PSTN_DL_FAIL = 0;
    cyc(1);
    PEER_RESTART_DONE = 1;
    cyc(1);
    PEER_RESTART_DONE = 0;
    drain("link failure restart");
    `CHK(MAINT_ERROR, 1'b0)
    report_and_stop();
  end
endmodule
`default_nettype wire
